/* rtl/pssc_map.vh */
// Purpose: Constants for the pipelined burst SRAM cycle control.
// Assumes: One rising-edge clock; memory lanes are nine bits wide.
// Notes: Included by bare name from the design files.
// How it works
// - Load with any chip select off starts deselect; outputs float after next edge.
// - Clock hold high makes the device ignore the edge and freeze all state except sleep entry and exit.
// - New access needs all selects, load low, hold low; write pin picks type.
// - Write data and parity are sampled at second recognised edge after start.
// - Advance after a read continues the burst, ignoring selects and write pin.
// - Advance after a write continues the write; lane enables sampled every beat.
// - Burst low bits: interleaved is first XOR beat, linear first plus beat.
// - Data lines driven only for a read in output stage with enable low.
// - After power-up the device is deselected and its lines float.
// - Write pin high means read; write with all lane enables high writes nothing.
// - Each low lane enable writes one byte with its parity; others unchanged.
// - Sleep request is asynchronous; entering or leaving sleep takes two cycles.
// - Memory kept in sleep; accesses pending at sleep entry are dropped.
// - Burst order low selects linear, high interleaved; two low bits wrap.
// - Access type is latched at burst start and kept for every beat.
// - From the cycle after a write starts, data lines float through data phase.
`ifndef PSSC_MAP_VH
`define PSSC_MAP_VH
`define PSSC_ADDR_WIDTH 19
`define PSSC_LANES 4
`define PSSC_LANE_BITS 9
`define PSSC_BYTE_BITS 8
`define PSSC_BURST_LINEAR 1'h0
`define PSSC_BURST_INTERLEAVED 1'h1
`define PSSC_SLEEP_ENTRY_CYC 2
`define PSSC_SLEEP_EXIT_CYC 2
`define PSSC_SLEEP_RECOVERY_TIME_CYC 2
`define PSSC_SLEEP_CNT_W 2
`endif

/* rtl/pssc_burst_seq.v */
// Purpose: Low two address bits of one burst beat.
// Assumes: Beat index counts 0 to 3 and wraps.
// Notes: Pure combinational.
`timescale 1ns/100ps
`include "pssc_map.vh"
module pssc_burst_seq (
   input wire [1:0] first_i,
   input wire [1:0] beat_i,
   input wire order_i,
   output wire [1:0] addr_o
);
   // Interleaved XOR or linear wrapping add
   assign addr_o = (order_i == `PSSC_BURST_INTERLEAVED) ?
                   (first_i ^ beat_i) : (first_i + beat_i);
endmodule

/* rtl/pssc_sram.v */
// Purpose: Cycle control and storage of a pipelined zero-latency SRAM.
// Assumes: Controller inputs are on clock_i; sleep request is asynchronous.
// Notes: Data bus is split into input, output and output enable.
`timescale 1ns/100ps
`include "pssc_map.vh"
module pssc_sram #(
   parameter ADDR_W = `PSSC_ADDR_WIDTH,
   parameter LANES = `PSSC_LANES
) (
   input wire clock_i,
   input wire reset_i,
   input wire [ADDR_W-1:0] addr_i,
   input wire chip_sel1_n_i,
   input wire chip_sel2_i,
   input wire chip_sel3_n_i,
   input wire clock_hold_n_i,
   input wire load_or_advance_i,
   input wire write_n_i,
   input wire [LANES-1:0] byte_lane_enables_n_i,
   input wire burst_order_i,
   input wire output_enable_n_i,
   input wire sleep_request_i,
   input wire [LANES*`PSSC_BYTE_BITS-1:0] data_i,
   input wire [LANES-1:0] parity_lines_i,
   output wire [LANES*`PSSC_BYTE_BITS-1:0] data_o,
   output wire [LANES-1:0] parity_lines_o,
   output wire data_oe_o,
   output reg asleep_o
);
   localparam DEPTH = 1 << ADDR_W;
   localparam BB = `PSSC_BYTE_BITS;
   localparam LB = `PSSC_LANE_BITS;

   // Sleep request synchroniser
   reg sleep_meta;
   reg sleep_sync;
   reg [`PSSC_SLEEP_CNT_W-1:0] sleep_cnt;

   // Burst state
   reg burst_live;
   reg burst_write;
   reg burst_order;
   reg [ADDR_W-1:0] burst_base;
   reg [1:0] burst_beat;

   // Address stage
   reg s1_valid;
   reg s1_write;
   reg [ADDR_W-1:0] s1_addr;
   reg [LANES-1:0] s1_lane_n;

   // Data stage
   reg s2_valid;
   reg s2_write;
   reg [ADDR_W-1:0] s2_addr;
   reg [LANES-1:0] s2_lane_n;

   // Output stage
   reg out_valid;

   wire all_sel;
   wire recog;
   wire do_load;
   wire do_desel;
   wire do_adv;
   wire [1:0] next_beat;
   wire [1:0] seq_low;
   wire [ADDR_W-1:0] adv_addr;
   wire [LANES-1:0] lane_wr;
   wire sleep_last;

   // Cycle decode
   assign all_sel = ~chip_sel1_n_i & chip_sel2_i & ~chip_sel3_n_i;
   assign recog = ~clock_hold_n_i & ~asleep_o;
   assign do_load = recog & ~load_or_advance_i & all_sel;
   assign do_desel = recog & ~load_or_advance_i & ~all_sel;
   assign do_adv = recog & load_or_advance_i & burst_live;
   assign next_beat = burst_beat + 2'h1;
   assign adv_addr = {burst_base[ADDR_W-1:2], seq_low};

   pssc_burst_seq u_seq (
      .first_i(burst_base[1:0]),
      .beat_i(next_beat),
      .order_i(burst_order),
      .addr_o(seq_low)
   );

   // Last cycle of a sleep entry or exit; the count runs
   // through clock hold so the bus cannot stall sleep
   assign sleep_last = sleep_sync ?
                       (sleep_cnt == `PSSC_SLEEP_ENTRY_CYC - 1) :
                       (sleep_cnt == `PSSC_SLEEP_EXIT_CYC - 1);

   // Two-flop sync of sleep request, then two-cycle entry and exit
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         sleep_meta <= 1'b0;
         sleep_sync <= 1'b0;
         sleep_cnt <= {`PSSC_SLEEP_CNT_W{1'b0}};
         asleep_o <= 1'b0;
      end else begin
         sleep_meta <= sleep_request_i;
         sleep_sync <= sleep_meta;
         // Request and state agree: nothing to count
         if (sleep_sync == asleep_o) begin
            sleep_cnt <= {`PSSC_SLEEP_CNT_W{1'b0}};
         end else if (sleep_last) begin
            sleep_cnt <= {`PSSC_SLEEP_CNT_W{1'b0}};
            asleep_o <= sleep_sync;
         end else begin
            sleep_cnt <= sleep_cnt + 1'b1;
         end
      end
   end

   // Burst counter and latched access type
   // An advance with no live burst loads nothing, like a deselect
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         burst_live <= 1'b0;
         burst_write <= 1'b0;
         burst_order <= `PSSC_BURST_LINEAR;
         burst_base <= {ADDR_W{1'b0}};
         burst_beat <= 2'h0;
      end else if (asleep_o) begin
         burst_live <= 1'b0;
      end else if (do_load) begin
         burst_live <= 1'b1;
         burst_write <= ~write_n_i;
         burst_order <= burst_order_i;
         burst_base <= addr_i;
         burst_beat <= 2'h0;
      end else if (do_adv) begin
         burst_beat <= next_beat;
      end else if (do_desel) begin
         burst_live <= 1'b0;
      end
   end

   // Address stage: only loads and advances carry an access
   // Lane enables travel with the address of each beat
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s1_valid <= 1'b0;
         s1_write <= 1'b0;
         s1_addr <= {ADDR_W{1'b0}};
         s1_lane_n <= {LANES{1'b1}};
      end else if (asleep_o) begin
         s1_valid <= 1'b0;
      end else if (recog) begin
         s1_valid <= do_load | do_adv;
         s1_write <= do_load ? ~write_n_i : burst_write;
         s1_addr <= do_load ? addr_i : adv_addr;
         s1_lane_n <= byte_lane_enables_n_i;
      end
   end

   // Data stage and output stage move on recognised edges only; while asleep their valid bits clear
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s2_valid <= 1'b0;
         s2_write <= 1'b0;
         s2_addr <= {ADDR_W{1'b0}};
         s2_lane_n <= {LANES{1'b1}};
         out_valid <= 1'b0;
      end else if (asleep_o) begin
         s2_valid <= 1'b0;
         out_valid <= 1'b0;
      end else if (recog) begin
         s2_valid <= s1_valid;
         s2_write <= s1_write;
         s2_addr <= s1_addr;
         s2_lane_n <= s1_lane_n;
         // Writes and deselects float the bus one edge later
         out_valid <= s1_valid & ~s1_write;
      end
   end

   // Lane write strobes at the write data edge
   assign lane_wr = (recog & s2_valid & s2_write) ?
                    ~s2_lane_n : {LANES{1'b0}};

   // Output drive follows output stage and async enable
   // Enable is asynchronous, so it gates the flop after the clock
   assign data_oe_o = out_valid & ~output_enable_n_i;

   // One storage array and output register per byte lane
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : lane
         reg [LB-1:0] lane_mem [0:DEPTH-1];
         reg [LB-1:0] lane_out;
         wire [LB-1:0] wr_word;
         wire bypass;

         assign wr_word = {parity_lines_i[g], data_i[g*BB +: BB]};
         // Read of the word being written this edge sees new data
         assign bypass = lane_wr[g] & (s2_addr == s1_addr);

         // Memory is never cleared, by reset or by sleep
         // Byte write; unselected lanes keep their contents
         always @(posedge clock_i) begin
            if (lane_wr[g] & ~asleep_o) begin
               lane_mem[s2_addr] <= wr_word;
            end
         end

         // Read data captured at the edge after address latch
         always @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
               lane_out <= {LB{1'b0}};
            end else if (recog & s1_valid & ~s1_write) begin
               lane_out <= bypass ? wr_word : lane_mem[s1_addr];
            end
         end

         assign data_o[g*BB +: BB] = lane_out[BB-1:0];
         assign parity_lines_o[g] = lane_out[BB];
      end
   endgenerate

endmodule

/* testbench/pssc_props.sv */
// Purpose: Port checks of the SRAM cycle control.
// Assumes: One clock; reset async high.
// Notes: Bound to pssc_sram below.
`timescale 1ns/100ps
module pssc_props (
   input wire clock_i,
   input wire reset_i,
   input wire chip_sel1_n_i,
   input wire chip_sel2_i,
   input wire chip_sel3_n_i,
   input wire clock_hold_n_i,
   input wire load_or_advance_i,
   input wire write_n_i,
   input wire output_enable_n_i,
   input wire sleep_request_i,
   input wire data_oe_o,
   input wire asleep_o
);
   // Recognised edge and full select
   wire rec = !clock_hold_n_i && !asleep_o;
   wire sel = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
   wire ld = rec && !load_or_advance_i;
   default clocking dc @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Load cycle followed by one recognised edge
   sequence s_desel; ld && !sel ##1 rec; endsequence
   sequence s_wr; ld && sel && !write_n_i ##1 rec; endsequence
   sequence s_rd; ld && sel && write_n_i ##1 rec; endsequence
   a_oe_needs_enable:
      assert property (data_oe_o |-> !output_enable_n_i) else $error("oe");
   a_deselect_floats:
      assert property (s_desel |=> !data_oe_o) else $error("desel");
   a_write_floats:
      assert property (s_wr |=> !data_oe_o) else $error("write");
   a_read_drives:
      assert property (s_rd |=> data_oe_o == !output_enable_n_i || asleep_o)
         else $error("read");
   a_hold_freezes:
      assert property (clock_hold_n_i && !asleep_o |=> asleep_o ||
         data_oe_o == $past(data_oe_o) || $changed(output_enable_n_i))
         else $error("hold");
   a_sleep_entry:
      assert property ($rose(sleep_request_i) |-> ##[2:6] asleep_o)
         else $error("sleep");
   a_sleep_exit:
      assert property ($fell(sleep_request_i) |-> ##[2:6] !asleep_o)
         else $error("wake");
   a_power_up:
      assert property ($fell(reset_i) |-> !data_oe_o && !asleep_o)
         else $error("reset");
   a_asleep_floats:
      assert property (asleep_o && $past(asleep_o) |-> !data_oe_o)
         else $error("asleep");
endmodule
bind pssc_sram pssc_props chk (.clock_i, .reset_i, .chip_sel1_n_i,
   .chip_sel2_i, .chip_sel3_n_i, .clock_hold_n_i, .load_or_advance_i,
   .write_n_i, .output_enable_n_i, .sleep_request_i, .data_oe_o, .asleep_o);

/* testbench/pssc_ctrl.sv */
// Purpose: Memory controller model.
// Assumes: Drives 1 ns after each rising edge.
// Notes: Write data lines toggle when not carrying data.
`timescale 1ns/100ps
module pssc_ctrl (
   input wire clock_i,
   output logic [5:0] addr_o = 6'h0,
   output logic sel1_n_o = 1'h1,
   output logic sel2_o = 1'h0,
   output logic hold_n_o = 1'h0,
   output logic ld_adv_o = 1'h0,
   output logic write_n_o = 1'h1,
   output logic [3:0] lanes_n_o = 4'hF,
   output logic order_o = 1'h0,
   output logic oe_n_o = 1'h0,
   output logic sleep_o = 1'h0,
   output logic [35:0] wdata_o = 36'h0
);
   // One cycle: c is hold, load/advance, select low, write low
   task cyc(input [3:0] c, input [5:0] a, input [3:0] be, input bit dv,
      input [35:0] d);
      @(posedge clock_i);
      #1;
      {hold_n_o, ld_adv_o, sel1_n_o, write_n_o} = c;
      sel2_o = !c[1];
      addr_o = a;
      lanes_n_o = be;
      wdata_o = dv ? d : ~wdata_o;
   endtask
   // Sleep request with device deselected throughout
   task rest(input bit z, input int n);
      sleep_o = z;
      repeat (n) cyc(4'h3, 6'h0, 4'hF, 1'b0, 36'h0);
   endtask
endmodule

/* testbench/pipelined_sram_cycle_control_test.sv */
// Purpose: Self-checking bench of the SRAM cycle control.
// Assumes: 100 MHz clock; six address bits.
// Notes: Read data shows two model calls after its load.
`timescale 1ns/100ps
`define CK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
   $display("BAD %0t %h %h", $time, a, e); end end
module pipelined_sram_cycle_control_test;
   logic clock_i = 0;
   logic reset_i = 1;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic s3_off = 0;
   wire [5:0] a;
   wire s1, s2, hn, la, wn, ord, oen, zz, oe, asleep;
   wire [3:0] be, po;
   wire [35:0] wd;
   wire [31:0] rd;
   wire [35:0] q = {po, rd};
   pssc_ctrl ctl (.clock_i(clock_i), .addr_o(a), .sel1_n_o(s1), .sel2_o(s2),
      .hold_n_o(hn), .ld_adv_o(la), .write_n_o(wn), .lanes_n_o(be),
      .order_o(ord), .oe_n_o(oen), .sleep_o(zz), .wdata_o(wd));
   pssc_sram #(.ADDR_W(6), .LANES(4)) dut (.clock_i(clock_i),
      .reset_i(reset_i), .addr_i(a), .chip_sel1_n_i(s1), .chip_sel2_i(s2),
      .chip_sel3_n_i(s1 | s3_off), .clock_hold_n_i(hn),
      .load_or_advance_i(la),
      .write_n_i(wn), .byte_lane_enables_n_i(be), .burst_order_i(ord),
      .output_enable_n_i(oen), .sleep_request_i(zz), .data_i(wd[31:0]),
      .parity_lines_i(wd[35:32]), .data_o(rd), .parity_lines_o(po),
      .data_oe_o(oe), .asleep_o(asleep));
   always #5 clock_i = ~clock_i;
   // Cut a hang short
   always @(posedge clock_i) begin
      if (++cycles == 2000) begin
         errors++;
         stop_test;
      end
   end
   task stop_test;
      if (errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Byte lanes merged by three back-to-back writes, then read
   task t_lanes;
      ctl.cyc(4'h0, 6'h5, 4'h0, 0, 0);
      ctl.cyc(4'h0, 6'h5, 4'hA, 0, 0);
      ctl.cyc(4'h0, 6'h5, 4'hF, 1, 36'hF11223344);
      ctl.cyc(4'h1, 6'h5, 4'hF, 1, 36'h0AABBCCDD);
      `CK(oe, 1'h0)
      ctl.cyc(4'h3, 6'h0, 4'hF, 1, 36'h555555555);
      ctl.cyc(4'h3, 6'h0, 4'hF, 0, 0);
      `CK(q, 36'hA11BB33DD)
   endtask
   // Linear burst write from 6, interleaved burst read from 5
   task t_burst;
      ctl.cyc(4'h0, 6'h6, 4'h0, 0, 0);
      ctl.cyc(4'h7, 6'h0, 4'h0, 0, 0);
      for (int i = 0; i < 4; i++)
         ctl.cyc(i < 2 ? 4'h7 : 4'h3, 6'h0, 4'h0, 1, 36'(i + 1));
      ctl.order_o = 1;
      ctl.cyc(4'h1, 6'h5, 4'hF, 0, 0);
      ctl.cyc(4'h4, 6'h0, 4'hF, 0, 0);
      for (int i = 0; i < 4; i++) begin
         ctl.cyc(i < 2 ? 4'h7 : 4'h3, 6'h0, 4'hF, 0, 0);
         `CK(q, 36'(4 - i))
      end
      ctl.cyc(4'h3, 6'h0, 4'hF, 0, 0);
      `CK(oe, 1'h0)
   endtask
   // Suspended edges stall the read and hold its output
   task t_hold;
      ctl.cyc(4'h1, 6'h6, 4'hF, 0, 0);
      repeat (3) ctl.cyc(4'hB, 6'h0, 4'hF, 0, 0);
      `CK(oe, 1'h0)
      ctl.cyc(4'h3, 6'h0, 4'hF, 0, 0);
      repeat (3) ctl.cyc(4'hB, 6'h0, 4'hF, 0, 0);
      `CK(q, 36'h1)
      `CK(oe, 1'h1)
      ctl.oe_n_o = 1;
      #1 `CK(oe, 1'h0)
      @(posedge clock_i) #1 ctl.oe_n_o = 0;
   endtask
   // Sleep and wake, memory kept
   task t_sleep;
      ctl.rest(1, 6);
      `CK(asleep, 1'h1)
      ctl.rest(0, 6);
      `CK(asleep, 1'h0)
      ctl.cyc(4'h1, 6'h7, 4'hF, 0, 0);
      repeat (2) ctl.cyc(4'h3, 6'h0, 4'hF, 0, 0);
      `CK(q, 36'h2)
   endtask
   // Third select alone off turns a read load into a deselect
   task t_select;
      s3_off = 1;
      ctl.cyc(4'h1, 6'h7, 4'hF, 0, 0);
      repeat (2) ctl.cyc(4'h3, 6'h0, 4'hF, 0, 0);
      `CK(oe, 1'h0)
      s3_off = 0;
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      #1 reset_i = 0;
      `CK(oe, 1'h0)
      t_lanes;
      t_burst;
      t_hold;
      t_sleep;
      t_select;
      stop_test;
   end
endmodule
